/* File: design/capture_defs.svh */
// Register offsets, field positions and reset values of the capture timer
`ifndef CAPTURE_DEFS_SVH
`define CAPTURE_DEFS_SVH

`define APB_AW        8
`define ADDR_MODE     8'h00
`define ADDR_CAPCMP   8'h04
`define ADDR_PRESCALE 8'h08
`define ADDR_OUTCTRL  8'h0C
`define ADDR_REG_A    8'h10
`define ADDR_REG_B    8'h14
`define ADDR_COUNT    8'h18
`define ADDR_STATUS   8'h1C

`define MODE_HI       3
`define MODE_LO       2
`define MODE_STOP     2'b00
`define MODE_FREE     2'b01
`define MODE_RESTART  2'b10
`define MODE_CLEAR    2'b11

`define CRC_A_CAP     0
`define CRC_A_SRC     1
`define CRC_B_CAP     2

`define CLK_HI        1
`define CLK_LO        0
`define ES_A_HI       5
`define ES_A_LO       4
`define ES_B_HI       7
`define ES_B_LO       6
`define EDGE_FALL     2'b00
`define EDGE_RISE     2'b01
`define EDGE_BOTH     2'b11

`define TOC_OE        0
`define TOC_TOG       1
`define STAT_WRAP     0

`define DIV_W         9
`define DIV_FAST      9'h001
`define DIV_MID       9'h007
`define DIV_SLOW      9'h1FF
`define DIV_ZERO      9'h000

`define RST_CTRL      8'h00
`define CNT_ZERO      16'h0000
`define CNT_ONE       16'h0001
`define CNT_MAX       16'hFFFF
`define WORD_ZERO     32'h0000_0000

`endif

/* File: design/capture_pkg.sv */
// Types shared by the capture timer modules
`include "capture_defs.svh"

package capture_pkg;

  typedef struct packed {
    logic                 psel;
    logic                 penable;
    logic                 pwrite;
    logic [`APB_AW-1:0]   paddr;
    logic [31:0]          pwdata;
  } apb_req_s;

  typedef enum logic [3:0] {
    RUN_STOP    = 4'b0001,
    RUN_FREE    = 4'b0010,
    RUN_RESTART = 4'b0100,
    RUN_CLEAR   = 4'b1000
  } run_e;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic samp;
    logic lvl;
    logic rise;
    logic fall;
  } filter_s;

  typedef struct packed {
    logic [7:0]          mode;
    logic [7:0]          crc;
    logic [7:0]          pre;
    logic [7:0]          toc;
    logic [15:0]         cnt;
    logic [15:0]         cap_a;
    logic [15:0]         cap_b;
    logic                wrap;
    logic [`DIV_W-1:0]   div;
    logic                out;
    logic                irq_a;
    logic                irq_b;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
  } core_s;

endpackage

/* File: design/pin_edge_filter.sv */
// Pin synchroniser and two-sample noise filter with edge pulses
`timescale 1ns/100ps
`include "capture_defs.svh"

module pin_edge_filter (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Count clock strobe
  input  wire logic tick,
  // Pin and filtered edges
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);
  import capture_pkg::*;

  filter_s st_reg;
  filter_s st_next;

  always_comb
  begin
    st_next       = st_reg;
    st_next.sync1 = pin;
    st_next.sync2 = st_reg.sync1;
    st_next.rise  = 1'b0;
    st_next.fall  = 1'b0;
    if (tick)
    begin
      st_next.samp = st_reg.sync2;
      // A short glitch never lasts two samples, so it never moves lvl
      if (st_reg.sync2 == st_reg.samp && st_reg.sync2 != st_reg.lvl)
      begin
        st_next.lvl  = st_reg.sync2;
        st_next.rise = st_reg.sync2;
        st_next.fall = ~st_reg.sync2;
      end
    end
  end

  // Level starts low, so a pin held high at reset yields one rising edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign rise = st_reg.rise;
  assign fall = st_reg.fall;

  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  filt_twice_a: assert property (
    st_reg.rise |-> st_reg.lvl && $past(st_reg.samp) && $past(st_reg.sync2))
    else $error("rise without two high samples");

  filt_fall_a: assert property (
    st_reg.fall |-> !st_reg.lvl && !$past(st_reg.samp) && !$past(st_reg.sync2))
    else $error("fall without two low samples");

endmodule

/* File: design/timer_pulse_capture_squarewave.sv */
// Capture, pulse-width and square-wave unit of a 16-bit timer with APB slave
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/100ps
`include "capture_defs.svh"

module timer_pulse_capture_squarewave (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire capture_pkg::apb_req_s apb_req,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Timer pins
  input  wire logic                  timer_in_a,
  input  wire logic                  timer_in_b,
  output logic                       timer_out_pin,
  // Interrupt request pulses
  output logic                       irq_match_a,
  output logic                       irq_capture_b
);
  import capture_pkg::*;

  ////////////////////////////////////////////////////////////////////////////

  core_s              state_reg;
  core_s              state_next;
  run_e               run;
  logic               running;
  logic               tick;
  logic               rise_a;
  logic               fall_a;
  logic               rise_b;
  logic               fall_b;
  logic [1:0]         es_a;
  logic [1:0]         es_b;
  logic               hit_a;
  logic               hit_b;
  logic               opp_a;
  logic               cap_a_evt;
  logic               cap_b_evt;
  logic               match;

  function automatic run_e decode_run(input logic [1:0] code);
    run_e r;
    r = RUN_STOP;
    case (code)
      `MODE_FREE:    r = RUN_FREE;
      `MODE_RESTART: r = RUN_RESTART;
      `MODE_CLEAR:   r = RUN_CLEAR;
      default:       r = RUN_STOP;
    endcase
    return r;
  endfunction

  // Code 10 is never written by software; it is treated as no edge
  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic       r,
                                    input logic       f);
    logic h;
    h = 1'b0;
    case (sel)
      `EDGE_FALL: h = f;
      `EDGE_RISE: h = r;
      `EDGE_BOTH: h = r | f;
      default:    h = 1'b0;
    endcase
    return h;
  endfunction

  // Edge opposite to the selected one; none when both edges are selected
  function automatic logic opposite_hit(input logic [1:0] sel,
                                        input logic       r,
                                        input logic       f);
    logic h;
    h = 1'b0;
    case (sel)
      `EDGE_FALL: h = r;
      `EDGE_RISE: h = f;
      default:    h = 1'b0;
    endcase
    return h;
  endfunction

  function automatic logic [`DIV_W-1:0] div_reload(input logic [1:0] sel);
    logic [`DIV_W-1:0] d;
    d = `DIV_FAST;
    case (sel)
      2'b01:   d = `DIV_MID;
      2'b10:   d = `DIV_SLOW;
      default: d = `DIV_FAST;
    endcase
    return d;
  endfunction

  function automatic logic is_mapped(input logic [`APB_AW-1:0] a);
    return (a[1:0] == 2'b00) && (a <= `ADDR_STATUS);
  endfunction

  function automatic logic [31:0] read_word(input logic [`APB_AW-1:0] a,
                                            input core_s            s);
    logic [31:0] w;
    w = `WORD_ZERO;
    case (a)
      `ADDR_MODE:     w = {24'h000000, s.mode};
      `ADDR_CAPCMP:   w = {24'h000000, s.crc};
      `ADDR_PRESCALE: w = {24'h000000, s.pre};
      `ADDR_OUTCTRL:  w = {24'h000000, s.toc};
      `ADDR_REG_A:    w = {16'h0000, s.cap_a};
      `ADDR_REG_B:    w = {16'h0000, s.cap_b};
      `ADDR_COUNT:    w = {16'h0000, s.cnt};
      `ADDR_STATUS:   w = {31'h00000000, s.wrap};
      default:        w = `WORD_ZERO;
    endcase
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Count clock and filtered pin edges

  assign run     = decode_run(state_reg.mode[`MODE_HI:`MODE_LO]);
  assign running = (run != RUN_STOP);
  assign tick    = running && (state_reg.div == `DIV_ZERO);
  assign es_a    = state_reg.pre[`ES_A_HI:`ES_A_LO];
  assign es_b    = state_reg.pre[`ES_B_HI:`ES_B_LO];

  pin_edge_filter u_filter_a (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick),
    .pin     (timer_in_a),
    .rise    (rise_a),
    .fall    (fall_a)
  );

  pin_edge_filter u_filter_b (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick),
    .pin     (timer_in_b),
    .rise    (rise_b),
    .fall    (fall_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Capture and match events

  assign hit_a = running && edge_hit(es_a, rise_a, fall_a);
  assign hit_b = (run == RUN_FREE) && edge_hit(es_b, rise_b, fall_b);
  assign opp_a = (run == RUN_FREE || run == RUN_RESTART)
                 && opposite_hit(es_a, rise_a, fall_a);

  // Pin A edge lands in reg B when CRC_B_CAP is set; free and restart modes only
  assign cap_b_evt = hit_a && state_reg.crc[`CRC_B_CAP]
                     && (run == RUN_FREE || run == RUN_RESTART);

  assign cap_a_evt = state_reg.crc[`CRC_A_CAP]
                     && (state_reg.crc[`CRC_A_SRC] ? opp_a : hit_b);

  // Compare match only while reg A acts as compare register
  assign match = tick && (run == RUN_CLEAR) && !state_reg.crc[`CRC_A_CAP]
                 && (state_reg.cnt == state_reg.cap_a);

  ////////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    logic setup;
    logic wr;
    setup = apb_req.psel && !apb_req.penable;
    wr    = apb_req.psel && apb_req.penable && state_reg.pready
            && apb_req.pwrite && !state_reg.pslverr;

    state_next       = state_reg;
    state_next.irq_a = 1'b0;
    state_next.irq_b = 1'b0;

    // Answer is prepared in setup, so access phase never waits
    state_next.pready  = setup;
    state_next.pslverr = setup && !is_mapped(apb_req.paddr);
    state_next.prdata  = (setup && !apb_req.pwrite)
                         ? read_word(apb_req.paddr, state_reg) : `WORD_ZERO;

    if (wr)
    begin
      case (apb_req.paddr)
        `ADDR_MODE:     state_next.mode  = apb_req.pwdata[7:0];
        `ADDR_CAPCMP:   state_next.crc   = apb_req.pwdata[7:0];
        `ADDR_PRESCALE: state_next.pre   = apb_req.pwdata[7:0];
        `ADDR_OUTCTRL:  state_next.toc   = apb_req.pwdata[7:0];
        `ADDR_REG_A:    state_next.cap_a = apb_req.pwdata[15:0];
        `ADDR_REG_B:    state_next.cap_b = apb_req.pwdata[15:0];
        `ADDR_STATUS:
        begin
          if (apb_req.pwdata[`STAT_WRAP])
            state_next.wrap = 1'b0;
        end
        default:        state_next.wrap = state_reg.wrap;
      endcase
    end

    // Prescaler: reload on stop so the first count period is whole
    if (!running || tick)
      state_next.div = div_reload(state_reg.pre[`CLK_HI:`CLK_LO]);
    else
      state_next.div = state_reg.div - `DIV_W'(1);

    // Counter; a wrap set after the software clear, so it wins
    if (!running)
      state_next.cnt = `CNT_ZERO;
    else if (match || (run == RUN_RESTART && hit_a))
      state_next.cnt = `CNT_ZERO;
    else if (tick)
    begin
      state_next.cnt = state_reg.cnt + `CNT_ONE;
      if (state_reg.cnt == `CNT_MAX)
        state_next.wrap = 1'b1;
    end

    // Captures override a software write in the same cycle
    if (cap_b_evt)
    begin
      state_next.cap_b = state_reg.cnt;
      state_next.irq_b = 1'b1;
    end
    if (cap_a_evt)
    begin
      state_next.cap_a = state_reg.cnt;
      state_next.irq_a = 1'b1;
    end
    if (match)
      state_next.irq_a = 1'b1;

    // A zero compare value would toggle every count clock
    if (!state_reg.toc[`TOC_OE])
      state_next.out = 1'b0;
    else if (match && state_reg.toc[`TOC_TOG])
      state_next.out = ~state_reg.out;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg       <= '0;
      state_reg.mode  <= `RST_CTRL;
      state_reg.crc   <= `RST_CTRL;
      state_reg.pre   <= `RST_CTRL;
      state_reg.toc   <= `RST_CTRL;
      state_reg.div   <= `DIV_FAST;
    end
    else
      state_reg <= state_next;
  end

  assign prdata        = state_reg.prdata;
  assign pready        = state_reg.pready;
  assign pslverr       = state_reg.pslverr;
  assign timer_out_pin = state_reg.out;
  assign irq_match_a   = state_reg.irq_a;
  assign irq_capture_b = state_reg.irq_b;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence restart_edge;
    run == RUN_RESTART && hit_a && state_reg.crc[`CRC_B_CAP];
  endsequence

  sequence restart_done;
    state_reg.cnt == `CNT_ZERO && irq_capture_b;
  endsequence

  sequence square_match;
    match && state_reg.toc[`TOC_OE] && state_reg.toc[`TOC_TOG];
  endsequence

  cap_b_value_a: assert property (
    cap_b_evt |=> irq_capture_b && state_reg.cap_b == $past(state_reg.cnt))
    else $error("reg B capture missed or wrong value");

  cap_a_pin_b_a: assert property (
    (run == RUN_FREE && state_reg.crc[`CRC_A_CAP]
     && !state_reg.crc[`CRC_A_SRC] && hit_b)
    |=> irq_match_a && state_reg.cap_a == $past(state_reg.cnt))
    else $error("pin B edge did not capture into reg A");

  opp_edge_a: assert property (
    (run == RUN_FREE && state_reg.crc[`CRC_A_CAP] && state_reg.crc[`CRC_A_SRC]
     && es_a == `EDGE_RISE && fall_a)
    |=> state_reg.cap_a == $past(state_reg.cnt) && irq_match_a)
    else $error("opposite edge did not capture into reg A");

  both_no_cap_a: assert property (
    (es_a == `EDGE_BOTH && state_reg.crc[`CRC_A_SRC]) |-> !cap_a_evt)
    else $error("reg A captured with both edges selected");

  restart_zero_a: assert property (
    restart_edge |=> restart_done)
    else $error("restart edge did not clear the counter");

  wrap_set_a: assert property (
    (run == RUN_FREE && tick && state_reg.cnt == `CNT_MAX)
    |=> state_reg.wrap && state_reg.cnt == `CNT_ZERO)
    else $error("counter wrap did not set wrap flag");

  count_step_a: assert property (
    (run == RUN_FREE && tick && $stable(state_reg.mode))
    |=> state_reg.cnt == $past(state_reg.cnt) + `CNT_ONE)
    else $error("free counter did not step by one");

  square_flip_a: assert property (
    square_match |=> timer_out_pin != $past(timer_out_pin)
                     && state_reg.cnt == `CNT_ZERO)
    else $error("square output did not toggle on match");

  irq_pulse_a: assert property (
    irq_capture_b |=> !irq_capture_b)
    else $error("capture interrupt longer than one clock");

endmodule

/* File: verif/pulse_source.sv */
// Pulse sources that stand on the two timer input pins
`timescale 1ns/100ps

module pulse_source (
  // Clock
  input  wire logic pclk,
  // Timer pins, both used as inputs by the unit
  output logic      pin_a,
  output logic      pin_b
);
  // Pins rest low so the unit's filter sees no edge at start
  initial
  begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end

  // High pulse of w clocks on pin a (sel 0) or pin b (sel 1), then a gap
  task automatic pulse(input bit sel, input int w, input int gap);
    @(posedge pclk);
    if (sel)
      pin_b <= 1'b1;
    else
      pin_a <= 1'b1;
    repeat (w) @(posedge pclk);
    if (sel)
      pin_b <= 1'b0;
    else
      pin_a <= 1'b0;
    repeat (gap) @(posedge pclk);
  endtask
endmodule

/* File: verif/timer_pulse_capture_squarewave_bench.sv */
// Self-checking bench for the capture and square-wave timer
`timescale 1ns/100ps
`include "capture_defs.svh"

module timer_pulse_capture_squarewave_bench;
  import capture_pkg::*;

  logic        pclk;
  logic        presetn;
  apb_req_s    apb_req;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin_a;
  logic        pin_b;
  logic        timer_out_pin;
  logic        irq_match_a;
  logic        irq_capture_b;
  int          num_errors;
  int          total_checks;
  int          cnt_a;
  int          cnt_b;
  int          w;
  logic        lvl;
  logic        clr_cnt;
  logic        err;
  logic [31:0] rd;
  logic [31:0] rd2;
  logic [1:0]  enc [3] = '{2'b00, 2'b01, 2'b11};

  timer_pulse_capture_squarewave uut (
    .pclk          (pclk),
    .presetn       (presetn),
    .apb_req       (apb_req),
    .prdata        (prdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .timer_in_a    (pin_a),
    .timer_in_b    (pin_b),
    .timer_out_pin (timer_out_pin),
    .irq_match_a   (irq_match_a),
    .irq_capture_b (irq_capture_b)
  );

  pulse_source src (
    .pclk  (pclk),
    .pin_a (pin_a),
    .pin_b (pin_b)
  );

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Interrupt pulses are one clock wide, so counting edges counts events
  always @(posedge pclk)
  begin
    if (!presetn || clr_cnt)
    begin
      cnt_a <= 0;
      cnt_b <= 0;
    end
    else
    begin
      cnt_a <= cnt_a + int'(irq_match_a === 1'b1);
      cnt_b <= cnt_b + int'(irq_capture_b === 1'b1);
    end
  end

  ////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_range(input logic [31:0] got, input logic [31:0] lo,
                             input logic [31:0] hi);
    total_checks++;
    if (^got === 1'bx || got < lo || got > hi)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h..%h", $time, got,
               lo, hi);
    end
  endtask

  // Answer stands one access cycle; values read right after an edge
  // are the ones that edge sampled
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rv,
                     output logic e);
    int t;
    t = 0;
    @(posedge pclk);
    apb_req <= '{psel:1'b1, penable:1'b0, pwrite:wr, paddr:a, pwdata:wd};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      t++;
    end
    while (pready !== 1'b1 && t < 50);
    if (pready !== 1'b1)
      num_errors++;
    rv = prdata;
    e = pslverr;
    apb_req <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d}, rd2, err);
  endtask

  task automatic clear_counts;
    clr_cnt <= 1'b1;
    @(posedge pclk);
    clr_cnt <= 1'b0;
  endtask

  // Stop first, then capture control, count clock and mode in that order
  task automatic setup(input logic [7:0] c, input logic [7:0] p,
                       input logic [7:0] m);
    wr(`ADDR_MODE, 8'h00);
    wr(`ADDR_CAPCMP, c);
    wr(`ADDR_PRESCALE, p);
    wr(`ADDR_MODE, m);
    clear_counts();
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////
  initial
  begin
    presetn = 1'b0;
    apb_req = '0;
    num_errors = 0;
    total_checks = 0;
    clr_cnt = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 32; a += 4)
    begin
      apb(1'b0, 8'(a), 32'h0, rd, err);
      check(rd, `WORD_ZERO);
    end
    apb(1'b0, 8'h20, 32'h0, rd, err);
    check({31'h0, err}, 32'h0000_0001);
    apb(1'b1, 8'h06, 32'h0000_0012, rd, err);
    check({31'h0, err}, 32'h0000_0001);
    wr(`ADDR_REG_A, 8'h5A);
    wr(`ADDR_COUNT, 8'h33);
    apb(1'b0, `ADDR_REG_A, 32'h0, rd, err);
    check(rd, 32'h0000_005A);
    apb(1'b0, `ADDR_COUNT, 32'h0, rd, err);
    check(rd, `WORD_ZERO);
    wr(`ADDR_STATUS, 8'h01);
    apb(1'b0, `ADDR_STATUS, 32'h0, rd, err);
    check(rd, `WORD_ZERO);
    // Pulse shorter than one count period is noise at pclk/8
    setup(8'h04, 8'h11, 8'h04);
    src.pulse(1'b0, 4, 60);
    check(32'(cnt_b), 32'h0);
    src.pulse(1'b0, 40, 60);
    check(32'(cnt_b), 32'h1);
    for (int i = 0; i < 3; i++)
    begin
      setup(8'h04, {2'b00, enc[i], 4'h0}, 8'h04);
      src.pulse(1'b0, 40, 40);
      check(32'(cnt_b), (i == 2) ? 32'h2 : 32'h1);
      check(32'(cnt_a), 32'h0);
    end
    setup(8'h05, 8'h50, 8'h04);
    src.pulse(1'b1, 40, 40);
    check(32'(cnt_a), 32'h1);
    check(32'(cnt_b), 32'h0);
    fork
      src.pulse(1'b0, 40, 40);
      src.pulse(1'b1, 40, 40);
    join
    check(32'(cnt_a), 32'h2);
    check(32'(cnt_b), 32'h1);
    setup(8'h07, 8'h10, 8'h04);
    src.pulse(1'b0, 40, 40);
    check(32'(cnt_b), 32'h1);
    apb(1'b0, `ADDR_REG_B, 32'h0, rd, err);
    apb(1'b0, `ADDR_REG_A, 32'h0, rd2, err);
    // Forty clocks at pclk/2 are twenty counts between the two captures
    check(rd2 - rd, 32'h0000_0014);
    setup(8'h07, 8'h30, 8'h04);
    src.pulse(1'b0, 40, 40);
    check(32'(cnt_b), 32'h2);
    check(32'(cnt_a), 32'h0);
    // Rising edge only in restart mode; count runs long before first edge
    setup(8'h04, 8'h10, 8'h08);
    repeat (200) @(posedge pclk);
    src.pulse(1'b0, 40, 30);
    src.pulse(1'b0, 40, 30);
    check(32'(cnt_b), 32'h2);
    apb(1'b0, `ADDR_REG_B, 32'h0, rd, err);
    check_range(rd, 32'h0000_001E, 32'h0000_0028);
    wr(`ADDR_MODE, 8'h00);
    wr(`ADDR_PRESCALE, 8'h00);
    wr(`ADDR_CAPCMP, 8'h00);
    wr(`ADDR_OUTCTRL, 8'h03);
    wr(`ADDR_REG_A, 8'h03);
    wr(`ADDR_MODE, 8'h0C);
    for (int k = 0; k < 2; k++)
    begin
      w = 0;
      lvl = timer_out_pin;
      while (timer_out_pin === lvl && w < 100)
      begin
        @(negedge pclk);
        w++;
      end
    end
    check(32'(w), 32'h8);
    wr(`ADDR_OUTCTRL, 8'h00);
    repeat (3) @(negedge pclk);
    check({31'h0, timer_out_pin}, 32'h0);
    end_of_test();
  end
endmodule
